/* File: src/flsm_cfg.svh */
/*
 * constants of the fiber link status monitor: register indexes, field positions,
 * state encodings and widths.
 * assumes inclusion by bare name from every file that needs them.
 */
`ifndef FLSM_CFG_SVH
`define FLSM_CFG_SVH

// ************************************************************
// register indexes (byte address is four times the index)
// ************************************************************
`define FLSM_IDX_FLAGS      14'h054
`define FLSM_IDX_RX_CNT     14'h055
`define FLSM_IDX_CRC_CNT    14'h056
`define FLSM_IDX_FMT_CNT    14'h057
`define FLSM_IDX_STATE      14'h058
`define FLSM_IDX_TX_CNT     14'h059
`define FLSM_IDX_CTRL       14'h05A
`define FLSM_LINK_B_STRIDE  14'h3E8

// ************************************************************
// error flag positions
// ************************************************************
`define FLSM_BIT_BAD_IRQ    0
`define FLSM_BIT_NO_EOF     1
`define FLSM_BIT_CRC_FRAME  2
`define FLSM_BIT_RX_OVERRUN 3
`define FLSM_BIT_LEN_FORMAT 4
`define FLSM_BIT_TX_UNDERRUN 5
`define FLSM_BIT_FAR_SYNC   6
`define FLSM_BIT_CTL_SYNC   8
`define FLSM_BIT_MUX_VERIFY 9
`define FLSM_BIT_OS_FAIL_LO 12
`define FLSM_FLAGS_RESET    16'h0000

// ************************************************************
// control register fields
// ************************************************************
`define FLSM_CTRL_FAULT_RST 0
`define FLSM_CTRL_WARN_RST  1

// ************************************************************
// link state encodings and thresholds
// ************************************************************
`define FLSM_PHASE_WAIT_OS  8'h01
`define FLSM_PHASE_DOWNLOAD 8'h02
`define FLSM_PHASE_EXCHANGE 8'h03
`define FLSM_PHASE_LOOPBACK 8'h06
`define FLSM_SYNC_OK        8'h01
`define FLSM_SYNC_LOST      8'h02
`define FLSM_SYNC_TICKS     2'h2
`define FLSM_ERR_RUN_FAULT  2'h2
`define FLSM_CNT_WIDTH      16

`endif

/* File: src/flsm_pkg.sv */
/*
 * types of the fiber link status monitor.
 * assumes flsm_cfg.svh is on the include path.
 */
`include "flsm_cfg.svh"

package flsm_pkg;

    typedef enum logic [7:0] {
        FLSM_WAIT_OS  = 8'h01,
        FLSM_DOWNLOAD = 8'h02,
        FLSM_EXCHANGE = 8'h03,
        FLSM_LOOPBACK = 8'h06
    } flsm_phase_type;

    typedef enum logic [7:0] {
        FLSM_SYNCED   = 8'h01,
        FLSM_UNSYNCED = 8'h02
    } flsm_sync_type;

endpackage

/* File: src/flsm_wrap_counter.sv */
/*
 * wrapping message counter, one per counted event and link.
 * assumes inc_in is a one-cycle pulse synchronous to clock_in.
 */
`timescale 1ns/1ps

module flsm_wrap_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock_in,
    input  wire logic             sys_rst_in,
    input  wire logic             clk_en_in,
    input  wire logic             inc_in,
    output logic      [WIDTH-1:0] count_out
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // rolls over to zero past the maximum
    assign count_next = count_reg + WIDTH'(1);
    assign count_out  = count_reg;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            count_reg <= '0;
        end else if (clk_en_in && inc_in) begin
            count_reg <= count_next;
        end
    end

endmodule

/* File: src/flsm_monitor.sv */
/*
 * fiber link status monitor: latched far-end error flags, message counters and
 * link state words for links a and b, read over apb.
 * assumes event inputs are one-cycle pulses synchronous to clock_in, and that the
 * far-end processor reports its own load failures on os_fail_in.
 */
// Contract
// [R1] far-end flags latch and hold until fault reset or warning reset.
// [R2] bit 0 sets on an improperly marked receive interrupt.
// [R3] bit 1 sets on receive interrupt without end-of-frame status.
// [R4] bit 2 sets on crc or framing error of last frame.
// [R5] bit 3 sets on receive fifo overrun.
// [R6] bit 4 sets when received length differs from encoded length.
// [R7] bit 5 sets on transmit fifo underrun.
// [R8] bit 6 sets after two far-end sync ticks with no message.
// [R9] bit 8 sets after two controller sync ticks with no message.
// [R10] bit 9 sets when multiplexed data fails verification.
// [R11] far end sets bit 12 for start address outside os area.
// [R12] far end sets bit 13 for insufficient memory to load os.
// [R13] far end sets bit 14 for invalid os load address.
// [R14] far end sets bit 15 when os load would overrun stack.
// [R15] after a load failure both ends keep retrying the download.
// [R16] 16-bit wrapping count of messages received at far end.
// [R17] separate counts of crc-error and format-error messages.
// [R18] state word: low byte link phase, high byte sync state.
// [R19] phase 01 waiting for os request, 02 downloading, 03 exchanging.
// [R20] phase 06 while external loopback test runs.
// [R21] high byte 01 synchronized, 02 unsynchronized.
// [R22] count transmitted messages on each port.
// [R23] two consecutive communication errors raise a fault stopping the drive.
// [R24] crc, format and transmit counters are 16 bits and wrap.
`timescale 1ns/1ps
`include "flsm_cfg.svh"

module flsm_monitor #(
    parameter int ADDR_W = 16
) (
    input  wire logic              clock_in,
    input  wire logic              sys_rst_in,
    input  wire logic              clk_en_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic [1:0]        bad_irq_in,
    input  wire logic [1:0]        no_eof_in,
    input  wire logic [1:0]        crc_frame_err_in,
    input  wire logic [1:0]        rx_overrun_in,
    input  wire logic [1:0]        len_format_err_in,
    input  wire logic [1:0]        tx_underrun_in,
    input  wire logic [1:0]        mux_verify_err_in,
    input  wire logic [1:0][3:0]   os_fail_in,
    input  wire logic [1:0]        far_sync_tick_in,
    input  wire logic [1:0]        far_rx_msg_in,
    input  wire logic [1:0]        far_crc_msg_in,
    input  wire logic [1:0]        far_fmt_msg_in,
    input  wire logic              ctl_sync_tick_in,
    input  wire logic [1:0]        ctl_rx_msg_in,
    input  wire logic [1:0]        tx_msg_in,
    input  wire logic [1:0]        os_request_in,
    input  wire logic [1:0]        download_done_in,
    input  wire logic [1:0]        loopback_in,
    output logic      [1:0]        comm_fault_out,
    output logic      [1:0][15:0]  link_state_out
);

    // ************************************************************
    // apb decode
    // ************************************************************
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        fault_rst_reg;
    logic        warn_rst_reg;

    wire  [13:0] word_idx   = 14'(paddr_in[ADDR_W-1:2]);
    wire  [13:0] rel_a      = word_idx - `FLSM_IDX_FLAGS;
    wire  [13:0] rel_b      = word_idx - (`FLSM_IDX_FLAGS + `FLSM_LINK_B_STRIDE);
    wire         hit_a      = (rel_a < 14'h006);
    wire         hit_b      = (rel_b < 14'h006);
    wire         hit_ctrl   = (word_idx == `FLSM_IDX_CTRL);
    wire  [2:0]  rel_sel    = hit_b ? rel_b[2:0] : rel_a[2:0];
    wire         link_sel   = hit_b;
    wire         mapped     = hit_a || hit_b || hit_ctrl;
    wire         access_go  = psel_in && penable_in && !pready_reg;
    wire         access_end = psel_in && penable_in && pready_reg;
    wire         ctrl_wr    = access_end && pwrite_in && hit_ctrl;
    wire         fault_clr  = ctrl_wr && pwdata_in[`FLSM_CTRL_FAULT_RST];
    wire         warn_clr   = ctrl_wr && pwdata_in[`FLSM_CTRL_WARN_RST];
    wire         any_clr    = fault_rst_reg || warn_rst_reg;

    // ************************************************************
    // per link state
    // ************************************************************
    logic [1:0][15:0] flags_reg;
    logic [1:0][15:0] flags_next;
    logic [1:0][1:0]  far_ticks_reg;
    logic [1:0][1:0]  ctl_ticks_reg;
    logic [1:0][1:0]  err_run_reg;
    logic [1:0]       fault_reg;
    logic [1:0][15:0] state_reg;
    logic [1:0][15:0] rx_cnt;
    logic [1:0][15:0] crc_cnt;
    logic [1:0][15:0] fmt_cnt;
    logic [1:0][15:0] tx_cnt;
    flsm_pkg::flsm_phase_type phase_reg [2];
    flsm_pkg::flsm_phase_type phase_next [2];

    genvar l;
    generate
        for (l = 0; l < 2; l++) begin : g_link
            wire [15:0] ev_set;
            wire        far_sync_hit = far_sync_tick_in[l] && !far_rx_msg_in[l]
                                       && (far_ticks_reg[l] != 2'h0);
            wire        ctl_sync_hit = ctl_sync_tick_in && !ctl_rx_msg_in[l]
                                       && (ctl_ticks_reg[l] != 2'h0);
            wire        comm_err     = ev_set[`FLSM_BIT_MUX_VERIFY] || (|ev_set[`FLSM_BIT_TX_UNDERRUN:0]);
            wire        synced       = (ctl_ticks_reg[l] < `FLSM_SYNC_TICKS);
            wire        os_failed    = |os_fail_in[l];

            assign ev_set[`FLSM_BIT_BAD_IRQ]     = bad_irq_in[l];          // R2
            assign ev_set[`FLSM_BIT_NO_EOF]      = no_eof_in[l];           // R3
            assign ev_set[`FLSM_BIT_CRC_FRAME]   = crc_frame_err_in[l];    // R4
            assign ev_set[`FLSM_BIT_RX_OVERRUN]  = rx_overrun_in[l];       // R5
            assign ev_set[`FLSM_BIT_LEN_FORMAT]  = len_format_err_in[l];   // R6
            assign ev_set[`FLSM_BIT_TX_UNDERRUN] = tx_underrun_in[l];      // R7
            assign ev_set[`FLSM_BIT_FAR_SYNC]    = far_sync_hit;           // R8
            assign ev_set[7]                     = 1'b0;
            assign ev_set[`FLSM_BIT_CTL_SYNC]    = ctl_sync_hit;           // R9
            assign ev_set[`FLSM_BIT_MUX_VERIFY]  = mux_verify_err_in[l];   // R10
            assign ev_set[11:10]                 = 2'h0;
            assign ev_set[15:12]                 = os_fail_in[l];

            // set wins over a same-cycle clear
            assign flags_next[l] = (any_clr ? `FLSM_FLAGS_RESET : flags_reg[l]) | ev_set; // R1

            // a load failure drops back to await the next request
            always_comb begin
                phase_next[l] = phase_reg[l];
                if (loopback_in[l]) begin
                    phase_next[l] = flsm_pkg::FLSM_LOOPBACK;                    // R20
                end else begin
                    case (phase_reg[l])
                        flsm_pkg::FLSM_WAIT_OS: begin
                            if (os_request_in[l]) begin
                                phase_next[l] = flsm_pkg::FLSM_DOWNLOAD;        // R19
                            end
                        end
                        flsm_pkg::FLSM_DOWNLOAD: begin
                            if (os_failed) begin
                                phase_next[l] = flsm_pkg::FLSM_WAIT_OS;         // R15
                            end else if (download_done_in[l]) begin
                                phase_next[l] = flsm_pkg::FLSM_EXCHANGE;        // R19
                            end
                        end
                        flsm_pkg::FLSM_EXCHANGE: begin
                            if (fault_reg[l]) begin
                                phase_next[l] = flsm_pkg::FLSM_WAIT_OS;         // R23
                            end
                        end
                        default: begin
                            phase_next[l] = flsm_pkg::FLSM_WAIT_OS;
                        end
                    endcase
                end
            end

            always_ff @(posedge clock_in) begin
                if (sys_rst_in) begin
                    flags_reg[l]     <= `FLSM_FLAGS_RESET;
                    far_ticks_reg[l] <= 2'h0;
                    ctl_ticks_reg[l] <= 2'h0;
                    err_run_reg[l]   <= 2'h0;
                    fault_reg[l]     <= 1'b0;
                    phase_reg[l]     <= flsm_pkg::FLSM_WAIT_OS;
                    state_reg[l]     <= 16'h0000;
                end else if (clk_en_in) begin
                    flags_reg[l] <= flags_next[l];
                    phase_reg[l] <= phase_next[l];
                    // tick counts saturate at the threshold
                    if (far_rx_msg_in[l]) begin
                        far_ticks_reg[l] <= 2'h0;
                    end else if (far_sync_tick_in[l] && far_ticks_reg[l] != `FLSM_SYNC_TICKS) begin
                        far_ticks_reg[l] <= far_ticks_reg[l] + 2'h1;
                    end
                    if (ctl_rx_msg_in[l]) begin
                        ctl_ticks_reg[l] <= 2'h0;
                    end else if (ctl_sync_tick_in && ctl_ticks_reg[l] != `FLSM_SYNC_TICKS) begin
                        ctl_ticks_reg[l] <= ctl_ticks_reg[l] + 2'h1;
                    end
                    // error run resets on a clean message
                    if (comm_err) begin
                        if (err_run_reg[l] != `FLSM_ERR_RUN_FAULT) begin
                            err_run_reg[l] <= err_run_reg[l] + 2'h1;
                        end
                    end else if (ctl_rx_msg_in[l]) begin
                        err_run_reg[l] <= 2'h0;
                    end
                    if (comm_err && err_run_reg[l] != 2'h0) begin
                        fault_reg[l] <= 1'b1;                                   // R23
                    end else if (fault_rst_reg) begin
                        fault_reg[l] <= 1'b0;
                    end
                    state_reg[l] <= {synced ? `FLSM_SYNC_OK : `FLSM_SYNC_LOST,  // R21
                                     8'(phase_next[l])};                        // R18
                end
            end

            flsm_wrap_counter #(.WIDTH(`FLSM_CNT_WIDTH)) u_rx_cnt (            // R16
                .clock_in   (clock_in),
                .sys_rst_in (sys_rst_in),
                .clk_en_in  (clk_en_in),
                .inc_in     (far_rx_msg_in[l]),
                .count_out  (rx_cnt[l])
            );
            flsm_wrap_counter #(.WIDTH(`FLSM_CNT_WIDTH)) u_crc_cnt (           // R17 R24
                .clock_in   (clock_in),
                .sys_rst_in (sys_rst_in),
                .clk_en_in  (clk_en_in),
                .inc_in     (far_crc_msg_in[l]),
                .count_out  (crc_cnt[l])
            );
            flsm_wrap_counter #(.WIDTH(`FLSM_CNT_WIDTH)) u_fmt_cnt (           // R17 R24
                .clock_in   (clock_in),
                .sys_rst_in (sys_rst_in),
                .clk_en_in  (clk_en_in),
                .inc_in     (far_fmt_msg_in[l]),
                .count_out  (fmt_cnt[l])
            );
            flsm_wrap_counter #(.WIDTH(`FLSM_CNT_WIDTH)) u_tx_cnt (            // R22 R24
                .clock_in   (clock_in),
                .sys_rst_in (sys_rst_in),
                .clk_en_in  (clk_en_in),
                .inc_in     (tx_msg_in[l]),
                .count_out  (tx_cnt[l])
            );
        end
    endgenerate

    // ************************************************************
    // read mux and apb slave
    // ************************************************************
    wire [15:0] rd_word = (rel_sel == 3'h0) ? flags_reg[link_sel] :
                          (rel_sel == 3'h1) ? rx_cnt[link_sel]    :
                          (rel_sel == 3'h2) ? crc_cnt[link_sel]   :
                          (rel_sel == 3'h3) ? fmt_cnt[link_sel]   :
                          (rel_sel == 3'h4) ? state_reg[link_sel] : tx_cnt[link_sel];
    wire [31:0] rd_data = (hit_a || hit_b) ? {16'h0000, rd_word} : 32'h0000_0000;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            prdata_reg    <= 32'h0000_0000;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            fault_rst_reg <= 1'b0;
            warn_rst_reg  <= 1'b0;
        end else if (clk_en_in) begin
            pready_reg    <= access_go;
            pslverr_reg   <= access_go && !mapped;
            fault_rst_reg <= fault_clr;
            warn_rst_reg  <= warn_clr;
            if (access_go) begin
                prdata_reg <= pwrite_in ? 32'h0000_0000 : rd_data;
            end
        end
    end

    assign prdata_out     = prdata_reg;
    assign pready_out     = pready_reg;
    assign pslverr_out    = pslverr_reg;
    assign comm_fault_out = fault_reg;
    assign link_state_out = state_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    a_flag_holds: assert property (                                                 // R1
        clk_en_in && !any_clr && flags_reg[0][`FLSM_BIT_CRC_FRAME]
        |=> flags_reg[0][`FLSM_BIT_CRC_FRAME])
        else $error("crc flag dropped without reset");
    a_irq_flag_set: assert property (                                               // R2
        clk_en_in && bad_irq_in[0] |=> flags_reg[0][`FLSM_BIT_BAD_IRQ])
        else $error("bad interrupt flag not set");
    a_underrun_set: assert property (                                               // R7
        clk_en_in && tx_underrun_in[1] |=> flags_reg[1][`FLSM_BIT_TX_UNDERRUN])
        else $error("underrun flag not set");
    a_overrun_set: assert property (                                                // R5
        clk_en_in && rx_overrun_in[0] && fault_rst_reg |=> flags_reg[0][`FLSM_BIT_RX_OVERRUN])
        else $error("overrun lost against clear");
    a_ctl_sync_two: assert property (                                               // R9
        clk_en_in && ctl_sync_tick_in && !ctl_rx_msg_in[0] && ctl_ticks_reg[0] == 2'h1
        |=> flags_reg[0][`FLSM_BIT_CTL_SYNC])
        else $error("controller sync flag missed second tick");
    a_far_sync_one: assert property (                                               // R8
        clk_en_in && !any_clr && far_ticks_reg[0] == 2'h0 && !flags_reg[0][`FLSM_BIT_FAR_SYNC]
        |=> !flags_reg[0][`FLSM_BIT_FAR_SYNC])
        else $error("far sync flag set before two ticks");
    a_rx_count_up: assert property (                                                // R16
        clk_en_in && far_rx_msg_in[0] |=> rx_cnt[0] == 16'($past(rx_cnt[0]) + 16'h0001))
        else $error("receive count did not advance");
    a_tx_count_hold: assert property (                                              // R22
        !tx_msg_in[1] |=> $stable(tx_cnt[1]))
        else $error("transmit count moved without message");
    a_phase_loop: assert property (                                                 // R20
        clk_en_in && loopback_in[0] |=> link_state_out[0][7:0] == `FLSM_PHASE_LOOPBACK)
        else $error("loopback phase not shown");
    a_sync_byte: assert property (                                                  // R21
        link_state_out[0][15:8] == `FLSM_SYNC_OK || link_state_out[0][15:8] == `FLSM_SYNC_LOST
        || link_state_out[0] == 16'h0000)
        else $error("bad sync byte");
    a_two_errors: assert property (                                                 // R23
        clk_en_in && bad_irq_in[0] ##1 clk_en_in && bad_irq_in[0] |=> comm_fault_out[0])
        else $error("two errors gave no fault");
    a_apb_wait: assert property (
        psel_in && penable_in && !pready_out && clk_en_in |=> pready_out)
        else $error("apb answer late");

    c_fault_seen: cover property (comm_fault_out[0]);
    c_exchange:   cover property (link_state_out[1][7:0] == `FLSM_PHASE_EXCHANGE);
    c_clear_flag: cover property (flags_reg[0] != 16'h0000 ##1 any_clr);

endmodule

/* File: sim/flsm_far_end_model.sv */
/* far-end power processor model: message, tick and image-load reports per link.
   assumes its tasks are entered just after a rising edge of clock_in. */
`timescale 1ns/1ps
module flsm_far_end_model (
    input  wire logic       clock_in,
    output logic      [1:0] far_rx_out,
    output logic      [1:0] far_crc_out,
    output logic      [1:0] far_fmt_out,
    output logic      [1:0] far_tick_out,
    output logic      [1:0] os_req_out,
    output logic [1:0][3:0] os_fail_out
);
    logic [1:0] pulses [4];
    assign far_rx_out   = pulses[0];
    assign far_crc_out  = pulses[1];
    assign far_fmt_out  = pulses[2];
    assign far_tick_out = pulses[3];
    initial begin
        pulses = '{default: 2'h0};
        os_req_out = 2'h0;
        os_fail_out = '0;
    end
    // *****
    // tasks
    // *****
    // n back-to-back pulses: kind 0 rx, 1 crc, 2 format, 3 sync tick
    task automatic send(input int link, input int kind, input int n);
        pulses[kind][link] <= 1'b1;
        repeat (n) @(posedge clock_in);
        pulses[kind][link] <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic request(input int link);
        os_req_out[link] <= 1'b1;
        @(posedge clock_in);
        os_req_out[link] <= 1'b0;
        @(posedge clock_in);
    endtask
    // failed image load, then the retry
    task automatic load_fail(input int link, input int code);
        request(link);
        os_fail_out[link] <= 4'h1 << code;
        @(posedge clock_in);
        os_fail_out[link] <= 4'h0;
        request(link);
    endtask
endmodule

/* File: sim/fiber_link_status_monitor_tb.sv */
/* self-checking bench of the fiber link status monitor: apb reads against a queue of notes.
   assumes flsm_cfg.svh on the include path and the far-end model compiled first. */
`timescale 1ns/1ps
`include "flsm_cfg.svh"
module fiber_link_status_monitor_tb;
    logic             clock_in = 1'b0;
    logic             rst = 1'b1;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic      [15:0] paddr = 16'h0000;
    logic      [31:0] pwdata = 32'h0000_0000;
    logic      [1:0]  ev [7] = '{default: 2'h0};
    logic             tick = 1'b0;
    logic      [1:0]  ctl_rx = 2'h0, tx = 2'h0, done = 2'h0, loopb = 2'h0;
    logic      [31:0] prdata;
    logic             pready, pslverr;
    logic      [1:0]  fault, f_rx, f_crc, f_fmt, f_tick, os_req;
    logic [1:0][3:0]  os_fail;
    logic [1:0][15:0] state;
    logic      [32:0] exp_q [$];
    logic      [15:0] acc;
    int               num_errors = 0, n_compared = 0, l, k;
    int               cnt [2][4];
    always #12.5 clock_in = ~clock_in;
    flsm_monitor i_flsm_monitor (.clock_in(clock_in), .sys_rst_in(rst), .clk_en_in(1'b1), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .bad_irq_in(ev[0]), .no_eof_in(ev[1]),
        .crc_frame_err_in(ev[2]), .rx_overrun_in(ev[3]), .len_format_err_in(ev[4]), .tx_underrun_in(ev[5]),
        .mux_verify_err_in(ev[6]), .os_fail_in(os_fail), .far_sync_tick_in(f_tick), .far_rx_msg_in(f_rx),
        .far_crc_msg_in(f_crc), .far_fmt_msg_in(f_fmt), .ctl_sync_tick_in(tick), .ctl_rx_msg_in(ctl_rx),
        .tx_msg_in(tx), .os_request_in(os_req), .download_done_in(done), .loopback_in(loopb),
        .comm_fault_out(fault), .link_state_out(state));
    flsm_far_end_model i_flsm_far_end_model (.clock_in(clock_in), .far_rx_out(f_rx), .far_crc_out(f_crc),
        .far_fmt_out(f_fmt), .far_tick_out(f_tick), .os_req_out(os_req), .os_fail_out(os_fail));
    // *******
    // harness
    // *******
    task automatic fail(input string m);
        num_errors++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic chk_rd(input logic [32:0] e);
        n_compared++;
        if ({pslverr, prdata} !== e) fail($sformatf("read %h want %h", {pslverr, prdata}, e));
    endtask
    task automatic chk_port(input int s, input logic [15:0] e);
        logic [15:0] g;
        repeat (2) @(posedge clock_in);
        g = (s < 2) ? state[s] : (s < 4) ? {15'h0, fault[s-2]} : {14'h0, fault};
        n_compared++;
        if (g !== e) fail($sformatf("port %h want %h", g, e));
    endtask
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [15:0] ba(input logic [13:0] idx, input logic link);
        return {idx + (link ? `FLSM_LINK_B_STRIDE : 14'h000), 2'b00};
    endfunction
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clock_in);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_in);
        if (i == 20) begin
            fail("no pready");
            end_sim();
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    always @(posedge clock_in) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) fail("read without note");
            else chk_rd(exp_q.pop_front());
        end
    end
    // *****
    // tests
    // *****
    initial begin
        void'($urandom(32'hF818));
        repeat (6) @(posedge clock_in);
        rst <= 1'b0;
        repeat (2) @(posedge clock_in);
        for (l = 0; l < 2; l++) begin
            for (k = 0; k < 6; k++) rd(ba(`FLSM_IDX_FLAGS + 14'(k), l[0]), (k == 4) ? 33'h0101 : 33'h0);
            chk_port(l, 16'h0101);
        end
        rd(16'h0200, 33'h1_0000_0000);
        $display("test reset done");
        for (l = 0; l < 2; l++) begin
            acc = 16'h0000;
            for (k = 0; k < 7; k++) begin
                ev[k][l] <= 1'b1;
                @(posedge clock_in);
                ev[k][l] <= 1'b0;
                @(posedge clock_in);
                acc = acc | (16'h0001 << ((k == 6) ? 9 : k));
                rd(ba(`FLSM_IDX_FLAGS, l[0]), {17'h0, acc});
            end
            apb(1'b1, ba(`FLSM_IDX_FLAGS, l[0]), 32'h0000_0000);
            rd(ba(`FLSM_IDX_FLAGS, l[0]), {17'h0, acc});
            chk_port(l + 2, 16'h0001);
        end
        for (k = 0; k < 4; k++) begin
            i_flsm_far_end_model.load_fail(1, k);
            acc = acc | (16'h1000 << k);
            rd(ba(`FLSM_IDX_FLAGS, 1'b1), {17'h0, acc});
            chk_port(1, 16'h0102);
        end
        apb(1'b1, {`FLSM_IDX_CTRL, 2'b00}, 32'h0000_0002);
        rd(ba(`FLSM_IDX_FLAGS, 1'b0), 33'h0);
        rd(ba(`FLSM_IDX_FLAGS, 1'b1), 33'h0);
        apb(1'b1, {`FLSM_IDX_CTRL, 2'b00}, 32'h0000_0001);
        chk_port(4, 16'h0000);
        $display("test flags done");
        i_flsm_far_end_model.send(0, 3, 2);
        tick <= 1'b1;
        repeat (2) @(posedge clock_in);
        tick <= 1'b0;
        rd(ba(`FLSM_IDX_FLAGS, 1'b0), 33'h0140);
        rd(ba(`FLSM_IDX_FLAGS, 1'b1), 33'h0100);
        chk_port(0, 16'h0201);
        ctl_rx <= 2'h1;
        @(posedge clock_in);
        ctl_rx <= 2'h0;
        chk_port(0, 16'h0101);
        chk_port(1, 16'h0202);
        $display("test sync done");
        i_flsm_far_end_model.request(0);
        chk_port(0, 16'h0102);
        done <= 2'h1;
        @(posedge clock_in);
        done <= 2'h0;
        rd(ba(`FLSM_IDX_STATE, 1'b0), 33'h0103);
        loopb <= 2'h1;
        chk_port(0, 16'h0106);
        loopb <= 2'h0;
        chk_port(0, 16'h0101);
        $display("test phase done");
        for (l = 0; l < 2; l++) begin
            for (k = 0; k < 4; k++) cnt[l][k] = 1 + $urandom % 20;
            for (k = 0; k < 3; k++) i_flsm_far_end_model.send(l, k, cnt[l][k]);
            tx[l] <= 1'b1;
            repeat (cnt[l][3]) @(posedge clock_in);
            tx[l] <= 1'b0;
            for (k = 0; k < 3; k++) rd(ba(`FLSM_IDX_RX_CNT + 14'(k), l[0]), 33'(cnt[l][k]));
            rd(ba(`FLSM_IDX_TX_CNT, l[0]), 33'(cnt[l][3]));
        end
        i_flsm_far_end_model.send(1, 0, 65536);
        rd(ba(`FLSM_IDX_RX_CNT, 1'b1), 33'(cnt[1][0]));
        $display("test counters done");
        end_sim();
    end
endmodule
